/* File: pkg/fots_consts.vh */
`ifndef FOTS_CONSTS_VH
`define FOTS_CONSTS_VH
// register indices, byte address is four times the index
`define FOTS_IDX_PARAM_INDEX 4'h1
`define FOTS_IDX_PARAM_WORD 4'h2
`define FOTS_IDX_CONFIG 4'h4
`define FOTS_IDX_ERR_CFG 4'h5
`define FOTS_IDX_CMD_STATUS 4'h6
`define FOTS_IDX_FAULT_STATUS 4'h7
// flash_config fields
`define FOTS_CFG_CC_IRQ_EN 7
`define FOTS_CFG_IGN_SGL 4
`define FOTS_CFG_FORCE_DBL 1
`define FOTS_CFG_FORCE_SGL 0
// flash_error_irq_config fields
`define FOTS_ERR_DBL_IRQ_EN 1
`define FOTS_ERR_SGL_IRQ_EN 0
// cmd_status_reg fields
`define FOTS_ST_CMD_DONE 7
`define FOTS_ST_ACCERR 5
`define FOTS_ST_FPVIOL 4
`define FOTS_ST_MGSTAT1 1
// fault_status_reg fields
`define FOTS_FS_DFD 1
`define FOTS_FS_SFD 0
// command parameters
`define FOTS_CMD_PROG_ONCE 8'h07
`define FOTS_PIDX_CMD 3'h0
`define FOTS_PIDX_PHRASE 3'h1
`define FOTS_PIDX_LAST 3'h5
`define FOTS_PHRASES 8
`define FOTS_MAX_PHRASE 16'h0007
// reset values
`define FOTS_RST_CONFIG 8'h00
`define FOTS_RST_ERR_CFG 8'h00
// timing
`define FOTS_CLK_NS 20
`define FOTS_PROG_TIME_NS 20000
`define FOTS_PROG_CYCLES ((`FOTS_PROG_TIME_NS + `FOTS_CLK_NS - 1) / `FOTS_CLK_NS)
// axi responses
`define FOTS_RESP_OKAY 2'b00
`define FOTS_RESP_SLVERR 2'b10
`endif

/* File: logic/fots_flash_otp.v */
`include "fots_consts.vh"
`default_nettype none
module fots_flash_otp #(
   parameter PROG_CYCLES = `FOTS_PROG_CYCLES
) (
   input wire core_clk,
   input wire rst_b,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire arr_rd_en,
   input wire [2:0] arr_rd_phrase,
   input wire arr_single_fault,
   input wire arr_double_fault,
   output reg [63:0] arr_rd_data,
   output reg arr_rd_valid,
   output wire cmd_complete_irq,
   output wire single_fault_irq,
   output wire double_fault_irq
);

   localparam S_IDLE = 4'b0001;
   localparam S_CHECK = 4'b0010;
   localparam S_PROG = 4'b0100;
   localparam S_VERIFY = 4'b1000;

   function mapped;
      input [3:0] idx;
      begin
         mapped = (idx == `FOTS_IDX_PARAM_INDEX) || (idx == `FOTS_IDX_PARAM_WORD) ||
                  (idx == `FOTS_IDX_CONFIG) || (idx == `FOTS_IDX_ERR_CFG) ||
                  (idx == `FOTS_IDX_CMD_STATUS) || (idx == `FOTS_IDX_FAULT_STATUS);
      end
   endfunction

   reg [7:0] awaddr_reg;
   reg aw_held_reg;
   reg [31:0] wdata_reg;
   reg [3:0] wstrb_reg;
   reg w_held_reg;
   reg [2:0] param_index_reg;
   reg [15:0] cmd_param_word [0:5];
   reg [7:0] flash_config;
   reg [7:0] flash_error_irq_config;
   reg cmd_complete_flag;
   reg acc_err_reg;
   reg prot_viol_reg;
   reg verify_err_reg;
   reg double_fault_flag;
   reg single_fault_flag;
   reg [3:0] state_reg;
   reg [15:0] cnt_reg;
   reg [2:0] phrase_reg;
   reg [63:0] otp_mem [0:`FOTS_PHRASES-1];
   reg [`FOTS_PHRASES-1:0] written_reg;
   reg [31:0] rd_mux;

   wire busy = ~state_reg[0];
   wire wr_go = aw_held_reg && w_held_reg && !s_axi_bvalid;
   wire [3:0] wr_idx = awaddr_reg[5:2];
   wire wr_ok = wr_go && mapped(wr_idx) && (awaddr_reg[7:6] == 2'b00);
   wire [3:0] rd_idx = s_axi_araddr[5:2];
   wire rd_go = s_axi_arvalid && !s_axi_rvalid;
   wire [63:0] new_phrase = {cmd_param_word[2], cmd_param_word[3],
                             cmd_param_word[4], cmd_param_word[5]};
   wire launch = wr_ok && (wr_idx == `FOTS_IDX_CMD_STATUS) && wstrb_reg[0] &&
                 wdata_reg[`FOTS_ST_CMD_DONE] && cmd_complete_flag;
   wire bad_cmd = (cmd_param_word[0][7:0] != `FOTS_CMD_PROG_ONCE) ||
                  (param_index_reg != `FOTS_PIDX_LAST) ||
                  (cmd_param_word[1] > `FOTS_MAX_PHRASE);
   wire arr_read = arr_rd_en && !busy;
   wire set_sf = arr_read && (flash_config[`FOTS_CFG_FORCE_SGL] ||
                 (arr_single_fault && !flash_config[`FOTS_CFG_IGN_SGL]));
   wire set_df = arr_read && (flash_config[`FOTS_CFG_FORCE_DBL] || arr_double_fault);
   wire reg_wr_lo = wr_ok && wstrb_reg[0];

   assign s_axi_awready = !aw_held_reg;
   assign s_axi_wready = !w_held_reg;
   assign s_axi_arready = !s_axi_rvalid;

   ////////////////////////////////////////////////////////////////////////
   // bus write side: address and data caught in either order

   always @(posedge core_clk) begin
      if (!rst_b) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0000_0000;
         wstrb_reg <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `FOTS_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `FOTS_RESP_OKAY : `FOTS_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers; parameter slots and config locked while busy

   always @(posedge core_clk) begin
      if (!rst_b) begin
         param_index_reg <= 3'h0;
         flash_config <= `FOTS_RST_CONFIG;
         flash_error_irq_config <= `FOTS_RST_ERR_CFG;
      end else if (reg_wr_lo && !busy) begin
         if (wr_idx == `FOTS_IDX_PARAM_INDEX)
            param_index_reg <= wdata_reg[2:0];
         if (wr_idx == `FOTS_IDX_CONFIG)
            flash_config <= wdata_reg[7:0] & 8'h93;
         if (wr_idx == `FOTS_IDX_ERR_CFG)
            flash_error_irq_config <= wdata_reg[7:0] & 8'h03;
      end
   end

   // slot array has no reset: only the written slots are ever used
   always @(posedge core_clk) begin
      if (wr_ok && !busy && (wr_idx == `FOTS_IDX_PARAM_WORD) && param_index_reg <= 3'h5) begin
         if (wstrb_reg[0])
            cmd_param_word[param_index_reg][7:0] <= wdata_reg[7:0];
         if (wstrb_reg[1])
            cmd_param_word[param_index_reg][15:8] <= wdata_reg[15:8];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // program-once sequencer

   always @(posedge core_clk) begin
      if (!rst_b) begin
         state_reg <= S_IDLE;
         cnt_reg <= 16'h0000;
         phrase_reg <= 3'h0;
         cmd_complete_flag <= 1'b1;
         acc_err_reg <= 1'b0;
         prot_viol_reg <= 1'b0;
         verify_err_reg <= 1'b0;
         written_reg <= {`FOTS_PHRASES{1'b0}};
      end else begin
         if (reg_wr_lo && (wr_idx == `FOTS_IDX_CMD_STATUS)) begin
            if (wdata_reg[`FOTS_ST_ACCERR])
               acc_err_reg <= 1'b0;
            if (wdata_reg[`FOTS_ST_FPVIOL])
               prot_viol_reg <= 1'b0;
         end
         case (state_reg)
            S_IDLE: begin
               if (launch && !acc_err_reg && !prot_viol_reg) begin
                  if (bad_cmd) begin
                     acc_err_reg <= 1'b1;
                  end else begin
                     cmd_complete_flag <= 1'b0;
                     verify_err_reg <= 1'b0;
                     phrase_reg <= cmd_param_word[1][2:0];
                     state_reg <= S_CHECK;
                  end
               end
            end
            S_CHECK: begin
               if (written_reg[phrase_reg]) begin
                  prot_viol_reg <= 1'b1;
                  cmd_complete_flag <= 1'b1;
                  state_reg <= S_IDLE;
               end else begin
                  cnt_reg <= 16'h0000;
                  state_reg <= S_PROG;
               end
            end
            S_PROG: begin
               if (cnt_reg == PROG_CYCLES - 1) begin
                  written_reg[phrase_reg] <= 1'b1;
                  state_reg <= S_VERIFY;
               end else begin
                  cnt_reg <= cnt_reg + 16'h0001;
               end
            end
            S_VERIFY: begin
               verify_err_reg <= (otp_mem[phrase_reg] != new_phrase);
               cmd_complete_flag <= 1'b1;
               state_reg <= S_IDLE;
            end
            default: state_reg <= S_IDLE;
         endcase
      end
   end

   // nonvolatile store: never erased; written once per reset, as reset clears written_reg
   always @(posedge core_clk) begin
      if (state_reg[2] && cnt_reg == PROG_CYCLES - 1)
         otp_mem[phrase_reg] <= new_phrase;
   end

   ////////////////////////////////////////////////////////////////////////
   // array read port and fault flags; a set beats a same-cycle clear

   always @(posedge core_clk) begin
      if (!rst_b) begin
         arr_rd_data <= 64'h0000_0000_0000_0000;
         arr_rd_valid <= 1'b0;
         single_fault_flag <= 1'b0;
         double_fault_flag <= 1'b0;
      end else begin
         arr_rd_valid <= arr_read;
         if (arr_rd_en)
            arr_rd_data <= busy ? 64'hffff_ffff_ffff_ffff :
                           written_reg[arr_rd_phrase] ? otp_mem[arr_rd_phrase] :
                           64'hffff_ffff_ffff_ffff;
         if (set_sf)
            single_fault_flag <= 1'b1;
         else if (reg_wr_lo && (wr_idx == `FOTS_IDX_FAULT_STATUS) && wdata_reg[`FOTS_FS_SFD])
            single_fault_flag <= 1'b0;
         if (set_df)
            double_fault_flag <= 1'b1;
         else if (reg_wr_lo && (wr_idx == `FOTS_IDX_FAULT_STATUS) && wdata_reg[`FOTS_FS_DFD])
            double_fault_flag <= 1'b0;
      end
   end

   assign cmd_complete_irq = cmd_complete_flag && flash_config[`FOTS_CFG_CC_IRQ_EN];
   assign single_fault_irq = single_fault_flag && flash_error_irq_config[`FOTS_ERR_SGL_IRQ_EN] &&
                             !flash_config[`FOTS_CFG_IGN_SGL];
   assign double_fault_irq = double_fault_flag && flash_error_irq_config[`FOTS_ERR_DBL_IRQ_EN];

   ////////////////////////////////////////////////////////////////////////
   // bus read side

   always @* begin
      case (rd_idx)
         `FOTS_IDX_PARAM_INDEX: rd_mux = {29'h0, param_index_reg};
         `FOTS_IDX_PARAM_WORD: rd_mux = (param_index_reg <= 3'h5) ?
                                        {16'h0, cmd_param_word[param_index_reg]} : 32'h0;
         `FOTS_IDX_CONFIG: rd_mux = {24'h0, flash_config};
         `FOTS_IDX_ERR_CFG: rd_mux = {24'h0, flash_error_irq_config};
         `FOTS_IDX_CMD_STATUS: rd_mux = {24'h0, cmd_complete_flag, 1'b0, acc_err_reg,
                                         prot_viol_reg, 2'b00, verify_err_reg, 1'b0};
         `FOTS_IDX_FAULT_STATUS: rd_mux = {30'h0, double_fault_flag, single_fault_flag};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge core_clk) begin
      if (!rst_b) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `FOTS_RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= (mapped(rd_idx) && s_axi_araddr[7:6] == 2'b00) ?
                        `FOTS_RESP_OKAY : `FOTS_RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // fots_flash_otp
`default_nettype wire

/* File: bench/fots_flash_otp_properties.sv */
`default_nettype none
module fots_flash_otp_chk #(
   parameter int PROG_CYCLES = 4
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic arr_rd_en,
   input wire logic arr_rd_valid,
   input wire logic cmd_complete_irq,
   input wire logic single_fault_irq,
   input wire logic double_fault_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////////
   wr_resp_hold_a:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   rd_data_hold_a:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   wr_latency_a:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
         |-> ##[1:2] s_axi_bvalid) else $error("write response late");
   // a taken read address is answered at the very next edge
   rd_latency_a:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   // a valid answer needs a request one edge before; whether it was made while busy is not checked
   arr_answer_a:
      assert property (arr_rd_valid |-> $past(arr_rd_en)) else $error("array answer uncaused");
   // flags only rise from an array read; enables only by a register write
   dbl_irq_cause_a:
      assert property ($rose(double_fault_irq) |-> $past(arr_rd_en) || s_axi_bvalid)
      else $error("double irq without cause");
   sgl_irq_cause_a:
      assert property ($rose(single_fault_irq) |-> $past(arr_rd_en) || s_axi_bvalid)
      else $error("single irq without cause");
   cc_irq_fall_a:
      assert property ($fell(cmd_complete_irq) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("complete irq fell without write");
endmodule // fots_flash_otp_chk
bind fots_flash_otp fots_flash_otp_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
   .core_clk(core_clk), .rst_b(rst_b), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .arr_rd_en(arr_rd_en), .arr_rd_valid(arr_rd_valid),
   .cmd_complete_irq(cmd_complete_irq), .single_fault_irq(single_fault_irq),
   .double_fault_irq(double_fault_irq));
`default_nettype wire

/* File: bench/tb.sv */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PROG = 8; // short program time keeps the run brief
   logic core_clk, rst_b, aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
   logic en, sf, df, a_v, cc, si, di;
   logic [7:0] aw_a, ar_a;
   logic [31:0] w_d, r_d;
   logic [3:0] w_s;
   logic [1:0] b_rsp, r_rsp;
   logic [2:0] ph;
   logic [63:0] a_d;
   logic [15:0] fc [7];
   logic [15:0] f;
   int n_fail = 0;
   int samples_checked = 0;
   int n;
   fots_flash_otp #(.PROG_CYCLES(PROG)) u_fots_flash_otp (.core_clk(core_clk), .rst_b(rst_b),
      .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
      .s_axi_wstrb(w_s), .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_rsp),
      .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
      .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_rsp), .s_axi_rvalid(r_v),
      .s_axi_rready(r_r), .arr_rd_en(en), .arr_rd_phrase(ph), .arr_single_fault(sf),
      .arr_double_fault(df), .arr_rd_data(a_d), .arr_rd_valid(a_v),
      .cmd_complete_irq(cc), .single_fault_irq(si), .double_fault_irq(di));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
      samples_checked++;
      if (e !== g) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one register access; response ready stands from the start, so the answer is taken
   // at the first edge that shows it; a missing answer is a mismatch, not a silent pass
   task automatic axi(input logic w, input logic [3:0] i, input logic [31:0] d);
      int k;
      logic got;
      k = 0;
      got = 1'b0;
      aw_a <= {2'b00, i, 2'b00};
      ar_a <= {2'b00, i, 2'b00};
      w_d <= d;
      aw_v <= w;
      w_v <= w;
      ar_v <= !w;
      b_r <= w;
      r_r <= !w;
      while (!got && k < 50) begin
         @(posedge core_clk);
         k++;
         if (aw_r === 1'b1) aw_v <= 1'b0;
         if (w_r === 1'b1) w_v <= 1'b0;
         if (ar_r === 1'b1) ar_v <= 1'b0;
         got = (w && b_v === 1'b1) || (!w && r_v === 1'b1);
      end
      b_r <= 1'b0;
      r_r <= 1'b0;
      chk("bus_answer", 1, got);
      if (w) begin
         chk("bresp", (i inside {1, 2, 4, 5, 6, 7}) ? 2'b00 : 2'b10, b_rsp);
      end else begin
         chk("rdata", d, r_d);
         chk("rresp", (i inside {1, 2, 4, 5, 6, 7}) ? 2'b00 : 2'b10, r_rsp);
      end
      @(posedge core_clk);
   endtask
   task automatic arr_rd(input logic [2:0] p, input logic s, input logic d, input logic ev,
      input logic [63:0] ed);
      en <= 1'b1;
      ph <= p;
      sf <= s;
      df <= d;
      @(posedge core_clk);
      en <= 1'b0;
      sf <= 1'b0;
      df <= 1'b0;
      @(posedge core_clk);
      chk("arr_valid", ev, a_v);
      chk("arr_data", ed, a_d);
   endtask
   task automatic prog(input logic [15:0] p, input logic [63:0] dat);
      axi(1, 1, 0);
      axi(1, 2, 32'h07);
      axi(1, 1, 1);
      axi(1, 2, {16'h0, p});
      for (int k = 0; k < 4; k++) begin
         axi(1, 1, k + 2);
         axi(1, 2, {16'h0, dat[63 - 16 * k -: 16]});
      end
      axi(1, 6, 32'h80);
   endtask
   task automatic done_in(output int c);
      c = 0;
      while (cc !== 1'b1 && c < 200) begin
         @(posedge core_clk);
         c++;
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_fail++;
      print_verdict;
   end
   initial begin
      // {config, err cfg, single, double, fault status, {double irq, single irq}}
      fc = '{16'h00c0, 16'h00e5, 16'h10e0, 16'h00da, 16'h03cf, 16'h030c, 16'h11c4};
      {rst_b, aw_v, w_v, b_r, ar_v, r_r, en, sf, df} = '0;
      {aw_a, ar_a, w_d, ph} = '0;
      w_s = 4'hf;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      axi(0, 4, 0);
      axi(0, 5, 0);
      axi(0, 6, 32'h80);
      axi(0, 7, 0);
      chk("cc_irq", 0, cc);
      axi(1, 5, 32'hff);
      axi(0, 5, 3);
      axi(1, 3, 1);
      axi(1, 8, 1);
      axi(0, 3, 0);
      $display("test registers done");
      for (int k = 0; k < 7; k++) begin
         f = fc[k];
         axi(1, 4, {24'h0, f[15:8]});
         axi(1, 5, {30'h0, f[7:6]});
         arr_rd(0, f[5], f[4], 1, '1);
         chk("fault_irq", f[1:0], {di, si});
         axi(0, 7, {30'h0, f[3:2]});
         axi(0, 4, {24'h0, f[15:8]});
         axi(1, 7, 3);
         chk("irq_clear", 0, {di, si});
      end
      $display("test fault_config done");
      axi(1, 4, 32'h80);
      chk("cc_irq", 1, cc);
      prog(2, 64'h0123_4567_89ab_cdef);
      chk("cc_busy", 0, cc);
      arr_rd(2, 0, 0, 0, '1);
      done_in(n);
      chk("prog_len", 1, (n + 5 >= PROG) && (n <= PROG + 4));
      axi(0, 6, 32'h80);
      arr_rd(2, 0, 0, 1, 64'h0123_4567_89ab_cdef);
      prog(2, 0);
      done_in(n);
      chk("refuse_len", 1, n < PROG);
      axi(0, 6, 32'h90);
      axi(1, 6, 32'h10);
      arr_rd(2, 0, 0, 1, 64'h0123_4567_89ab_cdef);
      prog(8, 0);
      axi(0, 6, 32'ha0);
      axi(1, 6, 32'h20);
      axi(0, 6, 32'h80);
      $display("test program_once done");
      print_verdict;
   end
endmodule // tb
`default_nettype wire
